// File: sbsc_cycle_ctrl.v
// Cycle decoder, burst counter and data pin control of a pipelined burst SRAM.
//
// How it works
// - Primary select high with controller strobe, or bad expansion selects, is deselect.
// - Sleep request high tristates all data pins at once, whatever else happens.
// - All selects on and processor strobe low begins a read burst, write ignored.
// - Selects on, controller strobe low, write strobe low begins a write burst.
// - Selects on, controller strobe low, write strobe high begins a read burst.
// - No strobe, advance low, write high reads the next burst address.
// - No strobe, advance low, write low writes the next burst address.
// - No strobe, advance high, write high rereads the current address.
// - No strobe, advance high, write low writes the current address again.
// - Write strobe is low on global write, or gate low with any lane low.
// - Output enable is never sampled and is masked during every write.
// - Reads drive all data bits while output enable is low, else tristate.
// - Writes happen only after a processor start, or on a controller start.
// - Gate low writes exactly the lanes whose select is low, with parity.
// - Low two address bits load a wrapping counter that steps on advance.
// - Burst order input low gives linear order, high gives interleaved.
// - Controller strobe is ignored while the processor strobe and primary select are low.
// - Sleep is entered three cycles after the request rises, left three after it falls.
`timescale 1ns/1ns
`include "sbsc_defines.vh"

module sbsc_cycle_ctrl (
  // Clock and reset
  input  wire                         clock,
  input  wire                         rstn,
  // Selects and strobes
  input  wire                         chip_select_primary_n,
  input  wire                         chip_select_expand_hi,
  input  wire                         chip_select_expand_n,
  input  wire                         proc_addr_strobe_n,
  input  wire                         ctrl_addr_strobe_n,
  input  wire                         burst_advance_n,
  // Write controls
  input  wire                         global_write_n,
  input  wire                         byte_write_gate_n,
  input  wire [`SBSC_LANES-1:0]       lane_write_select_n,
  // Asynchronous controls and burst order
  input  wire                         output_enable_n,
  input  wire                         sleep_request,
  input  wire                         burst_order,
  // Address
  input  wire [`SBSC_ADDR_W-1:0]      addr,
  // Data pins, lanes of eight data bits and one parity bit
  input  wire [`SBSC_DATA_W-1:0]      dq_in,
  output reg  [`SBSC_DATA_W-1:0]      dq_out,
  output wire [`SBSC_DATA_W-1:0]      dq_oe,
  // Memory core side
  output reg  [`SBSC_ADDR_W-1:0]      core_addr,
  output reg                          core_rd,
  output reg  [`SBSC_LANES-1:0]       core_wr_lane,
  output reg  [`SBSC_DATA_W-1:0]      core_wdata,
  input  wire [`SBSC_DATA_W-1:0]      core_rdata,
  // Status
  output reg                          asleep
);

  // ==========================================================================
  // Burst address order
  function [`SBSC_BURST_W-1:0] burst_low;
    input [`SBSC_BURST_W-1:0] start;
    input [`SBSC_BURST_W-1:0] step;
    input                     interleaved;
    begin
      if (interleaved) begin
        burst_low = start ^ step;
      end else begin
        burst_low = start + step;
      end
    end
  endfunction

  // ==========================================================================
  // Chip selects, all three active
  function selects_active;
    input primary_n;
    input expand_hi;
    input expand_n;
    begin
      selects_active = ~primary_n & expand_hi & ~expand_n;
    end
  endfunction

  // ==========================================================================
  // Write strobe, active when any lane is to be written
  function write_strobe_low;
    input                   global_n;
    input                   gate_n;
    input [`SBSC_LANES-1:0] lanes_n;
    begin
      write_strobe_low = ~global_n | (~gate_n & ~(&lanes_n));
    end
  endfunction

  // ==========================================================================
  // Lane write enables
  function [`SBSC_LANES-1:0] lanes_written;
    input                   global_n;
    input                   gate_n;
    input [`SBSC_LANES-1:0] lanes_n;
    begin
      if (!global_n) begin
        lanes_written = `SBSC_LANES_ALL;
      end else if (!gate_n) begin
        lanes_written = ~lanes_n;
      end else begin
        lanes_written = `SBSC_LANES_NONE;
      end
    end
  endfunction

  // ==========================================================================
  // State
  reg  [`SBSC_ST_W-1:0]    state_reg;
  reg  [`SBSC_ST_W-1:0]    state_next;
  reg                      burst_valid_reg;
  reg                      burst_valid_next;
  reg  [`SBSC_ADDR_W-1:0]  base_reg;
  reg  [`SBSC_ADDR_W-1:0]  base_next;
  reg  [`SBSC_BURST_W-1:0] step_reg;
  reg  [`SBSC_BURST_W-1:0] step_next;
  reg                      sleep_meta_reg;
  reg                      sleep_sync_reg;
  reg                      drive_reg;
  reg                      drive_next;
  reg                      asleep_next;
  reg  [`SBSC_LANES-1:0]   lanes_next;
  reg                      rd_next;
  reg  [`SBSC_ADDR_W-1:0]  addr_next;

  wire selects_on;
  wire proc_start;
  wire write_strobe_n;
  wire [`SBSC_LANES-1:0] lane_mask;
  wire [`SBSC_BURST_W-1:0] step_adv;

  // Any one select off turns a start into a deselect.
  assign selects_on = selects_active(chip_select_primary_n, chip_select_expand_hi,
                                     chip_select_expand_n);

  // The processor strobe only counts while the primary select is low.
  assign proc_start = ~proc_addr_strobe_n & ~chip_select_primary_n;

  assign write_strobe_n = ~write_strobe_low(global_write_n, byte_write_gate_n,
                                            lane_write_select_n);

  assign lane_mask = lanes_written(global_write_n, byte_write_gate_n,
                                   lane_write_select_n);

  assign step_adv = step_reg + `SBSC_BURST_ONE;

  // Both enables act without the clock, so a late change of either still
  // tristates the pins at once; only the read state itself is registered.
  assign dq_oe = {`SBSC_DATA_W{drive_reg & ~output_enable_n & ~sleep_request}};

  // ==========================================================================
  // Cycle decode
  always @* begin
    state_next       = `SBSC_ST_IDLE;
    burst_valid_next = burst_valid_reg;
    base_next        = base_reg;
    step_next        = step_reg;
    lanes_next       = `SBSC_LANES_NONE;
    rd_next          = 1'b0;
    addr_next        = core_addr;
    if (sleep_sync_reg) begin
      // Accesses caught by sleep are dropped and the burst is forgotten.
      state_next       = `SBSC_ST_SLEEP;
      burst_valid_next = 1'b0;
    end else if (proc_start) begin
      // A processor start reads when all selects are on; the controller strobe is dropped.
      if (selects_on) begin
        state_next       = `SBSC_ST_READ;
        burst_valid_next = 1'b1;
        base_next        = addr;
        step_next        = `SBSC_BURST_ZERO;
        rd_next          = 1'b1;
        addr_next        = addr;
      end else begin
        burst_valid_next = 1'b0;
      end
    end else if (~ctrl_addr_strobe_n) begin
      if (selects_on) begin
        burst_valid_next = 1'b1;
        base_next        = addr;
        step_next        = `SBSC_BURST_ZERO;
        addr_next        = addr;
        if (~write_strobe_n) begin
          state_next = `SBSC_ST_WRITE;
          lanes_next = lane_mask;
        end else begin
          state_next = `SBSC_ST_READ;
          rd_next    = 1'b1;
        end
      end else begin
        burst_valid_next = 1'b0;
      end
    end else if (burst_valid_reg) begin
      // Continue and suspend need a live burst; without one the edge is idle.
      // The counter wraps inside four words and never carries into the base.
      if (~burst_advance_n) begin
        step_next = step_adv;
      end
      addr_next = {base_reg[`SBSC_ADDR_W-1:`SBSC_BURST_W],
                   burst_low(base_reg[`SBSC_BURST_W-1:0], step_next, burst_order)};
      if (~write_strobe_n) begin
        state_next = `SBSC_ST_WRITE;
        lanes_next = lane_mask;
      end else begin
        state_next = `SBSC_ST_READ;
        rd_next    = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Data pin drive and sleep status
  // A read keeps the pins for one cycle after it; a write decoded at the
  // same edge masks them, so a late output enable cannot fight the data.
  always @* begin
    drive_next  = 1'b0;
    asleep_next = sleep_sync_reg;
    case (state_reg)
      `SBSC_ST_READ: begin
        drive_next = (state_next != `SBSC_ST_WRITE);
      end
      `SBSC_ST_WRITE: begin
        drive_next = 1'b0;
      end
      `SBSC_ST_SLEEP: begin
        drive_next = 1'b0;
      end
      default: begin
        drive_next = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Sleep synchroniser
  // Only the second flop is read, since the first may still be settling.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sleep_meta_reg <= 1'b0;
      sleep_sync_reg <= 1'b0;
    end else begin
      sleep_meta_reg <= sleep_request;
      sleep_sync_reg <= sleep_meta_reg;
    end
  end

  // ==========================================================================
  // Burst registers
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg       <= `SBSC_ST_IDLE;
      burst_valid_reg <= 1'b0;
      base_reg        <= `SBSC_ADDR_ZERO;
      step_reg        <= `SBSC_BURST_ZERO;
    end else begin
      state_reg       <= state_next;
      burst_valid_reg <= burst_valid_next;
      base_reg        <= base_next;
      step_reg        <= step_next;
    end
  end

  // ==========================================================================
  // Memory core side
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      core_addr    <= `SBSC_ADDR_ZERO;
      core_rd      <= 1'b0;
      core_wr_lane <= `SBSC_LANES_NONE;
      core_wdata   <= `SBSC_DATA_ZERO;
    end else begin
      core_addr    <= addr_next;
      core_rd      <= rd_next;
      core_wr_lane <= lanes_next;
      core_wdata   <= dq_in;
    end
  end

  // ==========================================================================
  // Data pins and status
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dq_out    <= `SBSC_DATA_ZERO;
      drive_reg <= 1'b0;
      asleep    <= 1'b0;
    end else begin
      // The core answers in the cycle of its read, so the pins follow one
      // cycle later and a write cycle never turns the pins around.
      dq_out    <= core_rdata;
      drive_reg <= drive_next;
      asleep    <= asleep_next;
    end
  end

endmodule // sbsc_cycle_ctrl

// File: sbsc_defines.vh
// Shared widths, encodings and reset values for the burst SRAM cycle control.
`ifndef SBSC_DEFINES_VH
`define SBSC_DEFINES_VH

// ==========================================================================
// Widths
`define SBSC_ADDR_W      20
`define SBSC_LANES       4
`define SBSC_LANE_W      9
`define SBSC_DATA_W      36
`define SBSC_BURST_W     2

// ==========================================================================
// Cycle states, one-hot
`define SBSC_ST_W        4
`define SBSC_ST_IDLE     4'h1
`define SBSC_ST_READ     4'h2
`define SBSC_ST_WRITE    4'h4
`define SBSC_ST_SLEEP    4'h8

// ==========================================================================
// Constants
`define SBSC_LANES_NONE  4'h0
`define SBSC_LANES_ALL   4'hF
`define SBSC_ADDR_ZERO   20'h0_0000
`define SBSC_DATA_ZERO   36'h0_0000_0000
`define SBSC_BURST_ZERO  2'h0
`define SBSC_BURST_ONE   2'h1

`endif

// File: sbsc_cycle_ctrl_sva.sv
// Port checker of the burst SRAM cycle control, bound to its top module.
`timescale 1ns/1ns
module sbsc_cycle_ctrl_sva (
  // Every port of the cycle control, watched only
  input wire chip_select_primary_n, chip_select_expand_hi, chip_select_expand_n,
  input wire clock, rstn, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
  input wire global_write_n, byte_write_gate_n, output_enable_n, sleep_request,
  input wire burst_order, core_rd, asleep,
  input wire [3:0]  lane_write_select_n, core_wr_lane,
  input wire [19:0] addr, core_addr,
  input wire [35:0] dq_in, dq_out, dq_oe, core_wdata, core_rdata
);
  // ==========================================================================
  // Helpers
  // Four clean samples are demanded, three past and the current one, so the decoder's synchroniser has settled.
  reg  [2:0] sleep_hist_reg;
  wire       awake = sleep_hist_reg == 3'h0 && !sleep_request;
  wire       sel   = !chip_select_primary_n && chip_select_expand_hi && !chip_select_expand_n;
  wire       no_st = proc_addr_strobe_n && ctrl_addr_strobe_n && awake;
  wire       busy  = core_rd || core_wr_lane != 4'h0;
  wire [3:0] mask  = !global_write_n ? 4'hF : byte_write_gate_n ? 4'h0 : ~lane_write_select_n;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) sleep_hist_reg <= 3'h0;
    else sleep_hist_reg <= {sleep_hist_reg[1:0], sleep_request};
  end
  // ==========================================================================
  // Assertions
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_DESEL: assert property (chip_select_primary_n && !ctrl_addr_strobe_n |=> !busy)
    else $error("deselect cycle made a core access");
  AST_PROC_RD: assert property (awake && sel && !proc_addr_strobe_n |=>
    core_rd && core_wr_lane == 4'h0 && core_addr == $past(addr)) else $error("bad processor start");
  AST_CTRL: assert property (awake && sel && proc_addr_strobe_n && !ctrl_addr_strobe_n |=>
    core_wr_lane == $past(mask) && core_rd == ($past(mask) == 4'h0) && core_addr == $past(addr))
    else $error("bad controller start");
  AST_SLEEP_TRI: assert property (sleep_request |-> dq_oe == 36'h0)
    else $error("data driven while sleep requested");
  AST_OE_TRI: assert property (output_enable_n || core_wr_lane != 4'h0 |-> dq_oe == 36'h0)
    else $error("data driven with output enable off or in a write");
  AST_RD_DRV: assert property (core_rd ##1 (core_rd && !output_enable_n && !sleep_request) |->
    dq_oe == {36{1'b1}} && dq_out == $past(core_rdata)) else $error("read data not driven");
  AST_CONT: assert property (no_st && !burst_advance_n && !burst_order && busy |=>
    core_addr[1:0] == $past(core_addr[1:0]) + 2'h1) else $error("linear step wrong");
  AST_SUSP: assert property (no_st && burst_advance_n && busy |=> core_addr == $past(core_addr))
    else $error("suspend moved the address");
  AST_SLEEP_IN: assert property ($rose(sleep_request) ##1 sleep_request[*2] |=> asleep)
    else $error("sleep not entered in time");
  AST_SLEEP_OUT: assert property ($fell(sleep_request) ##1 !sleep_request[*2] |=> !asleep)
    else $error("sleep not left in time");
endmodule // sbsc_cycle_ctrl_sva

bind sbsc_cycle_ctrl sbsc_cycle_ctrl_sva i_sva (.*);

// File: sbsc_core_model.sv
// Memory core stand-in answering the core side of the cycle control.
`timescale 1ns/1ns
module sbsc_core_model (
  // Core side
  input  wire        clock,
  input  wire [19:0] core_addr,
  input  wire [3:0]  core_wr_lane,
  input  wire [35:0] core_wdata,
  output wire [35:0] core_rdata
);
  // Sixteen words suffice; upper address bits alias, which the tests avoid.
  reg [35:0] mem [0:15];
  integer    i;
  integer    j;
  assign core_rdata = mem[core_addr[3:0]];
  initial for (i = 0; i < 16; i = i + 1) mem[i] = 36'h9_0000_0000 + i;
  always @(posedge clock) begin
    for (j = 0; j < 4; j = j + 1) begin
      if (core_wr_lane[j]) mem[core_addr[3:0]][9*j +: 9] <= core_wdata[9*j +: 9];
    end
  end
endmodule // sbsc_core_model

// File: sbsc_cycle_ctrl_tb.sv
// Self-checking testbench of the burst SRAM cycle control.
`timescale 1ns/1ns
module sbsc_cycle_ctrl_tb;
  // ==========================================================================
  // Signals
  localparam [35:0] WORD = 36'hA_5C3E_91B7;
  reg clock = 1'b0, rstn = 1'b0, chip_select_primary_n = 1'b1, chip_select_expand_hi = 1'b1;
  reg chip_select_expand_n = 1'b0, proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b0;
  reg burst_advance_n = 1'b1, global_write_n = 1'b1, byte_write_gate_n = 1'b1;
  reg output_enable_n = 1'b1, sleep_request = 1'b0, burst_order = 1'b0;
  reg  [3:0]  lane_write_select_n = 4'hF;
  reg  [19:0] addr = 20'h0;
  reg  [35:0] dq_in = 36'h0;
  wire        core_rd, asleep;
  wire [3:0]  core_wr_lane;
  wire [19:0] core_addr;
  wire [35:0] dq_out, dq_oe, core_wdata, core_rdata;
  integer     n_mismatch = 0, n_compared = 0;
  sbsc_cycle_ctrl i_dut (.*);
  sbsc_core_model i_core (.*);
  initial forever #5 clock = ~clock;
  // ==========================================================================
  // Shared tasks
  task put(input c, p, s, v, g, b, input [3:0] l, input [19:0] a, input [35:0] d);
    @(posedge clock);
    {chip_select_primary_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
     global_write_n, byte_write_gate_n, lane_write_select_n, addr, dq_in} <= {c, p, s, v, g, b, l, a, d};
  endtask
  // A deselect is the only quiet cycle, since suspend would keep a burst alive.
  task idle;
    put(1, 1, 0, 1, 1, 1, 4'hF, 20'h0, 36'h0);
  endtask
  task chk(input [35:0] seen, exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task t_wr_rd;
    put(0, 0, 1, 1, 1, 1, 4'hF, 20'h5, 36'h0);
    put(0, 1, 0, 1, 0, 1, 4'hF, 20'h5, WORD);
    put(0, 0, 1, 1, 0, 1, 4'hF, 20'h5, 36'h0);
    output_enable_n <= 1'b0;
    #1 chk({core_wr_lane, core_wdata}, {4'hF, WORD});
    chk(dq_oe, 36'h0);
    put(0, 0, 0, 1, 0, 1, 4'hF, 20'h5, 36'h0);
    #1 chk({core_rd, core_wr_lane, core_addr}, {1'b1, 4'h0, 20'h5});
    put(0, 0, 1, 1, 1, 1, 4'hF, 20'h5, 36'h0);
    #1 chk({core_rd, core_wr_lane}, 5'h10);
    chk(dq_out, WORD);
    chk(dq_oe, {36{1'b1}});
    put(0, 0, 1, 1, 1, 1, 4'hF, 20'h5, 36'h0);
    output_enable_n <= 1'b1;
    #1 chk(dq_oe, 36'h0);
    $display("write then read done");
  endtask
  task t_lanes;
    integer k;
    for (k = 0; k < 17; k = k + 1) begin
      put(0, 1, 0, 1, 1, k == 16, k == 16 ? 4'h0 : ~k[3:0], 20'h6, WORD);
      idle;
      #1 chk({core_rd, core_wr_lane}, k == 16 ? 5'h10 : {k[3:0] == 4'h0, k[3:0]});
    end
    $display("lane selects done");
  endtask
  task t_burst;
    integer o, j;
    reg [1:0] st, e;
    for (o = 0; o < 2; o = o + 1) begin
      idle;
      burst_order <= o[0];
      put(0, 0, 1, 1, 1, 1, 4'hF, 20'h1, 36'h0);
      for (j = 1; j < 6; j = j + 1) begin
        if (j < 5) put(0, 1, 1, j == 4, o == 0, 1, 4'hF, 20'h1, WORD);
        else idle;
        st = j == 5 ? 2'h3 : j - 1;
        e = o ? 2'h1 ^ st : 2'h1 + st;
        #1 chk({core_rd, core_wr_lane, core_addr[1:0]},
               {j == 1 || o == 0, j > 1 && o ? 4'hF : 4'h0, e});
      end
    end
    $display("burst order done");
  endtask
  task t_sleep;
    integer k;
    put(0, 0, 1, 1, 1, 1, 4'hF, 20'h2, 36'h0);
    output_enable_n <= 1'b0;
    put(0, 0, 1, 1, 1, 1, 4'hF, 20'h2, 36'h0);
    idle;
    #1 chk(dq_oe, {36{1'b1}});
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge clock) sleep_request <= k == 0;
      #1 chk(dq_oe, 36'h0);
      repeat (2) @(posedge clock);
      #1 chk(asleep, k == 1);
      @(posedge clock);
      #1 chk(asleep, k == 0);
    end
    repeat (2) @(posedge clock);
    $display("sleep done");
  endtask
  // ==========================================================================
  // Sequence and watchdog
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_wr_rd;
    t_lanes;
    t_burst;
    t_sleep;
    close_out;
  end
  initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end
endmodule // sbsc_cycle_ctrl_tb
